// ==== dv/pwc_sva.sv ====
// Port assertions for the periodic wakeup counter
`timescale 1ns/1ps
module pwc_sva
  import pwc_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Interrupt
  input wire logic        match_irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hC
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_irq_fall: assert property ($fell(match_irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a write");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    !match_irq && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active after reset");
endmodule

bind pwc_top pwc_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .match_irq);

// ==== dv/pwc_tb.sv ====
// Self-checking bench for the periodic wakeup counter
`timescale 1ns/1ps
module testbench;
  import pwc_pkg::*;
  logic        aclk = 0, aresetn = 0, debug_halt = 0, match_irq;
  logic        low_power_osc_clock = 0, external_ref_clock = 0, internal_ref_clock = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irq_q = 0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] exq[$];
  int          err_total = 0, n_compared = 0, cyc = 0, n_rise = 0, t_rise = 0, t0, n;
  // Settings per case: control byte, modulo, expected flag period in cycles
  logic [7:0]  cfg[10] = '{8'h08, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h01, 8'h48, 8'h28};
  logic [7:0]  md[10] = '{8'h03, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int          gap[10] = '{64, 16, 64, 64, 160, 256, 1600, 128, 24, 8000};

  pwc_top dut (.*);

  always #20 aclk = ~aclk;

  // Sources: periods of 16, 8 and 24 cycles; interrupt rise log
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    low_power_osc_clock <= (cyc % 16) < 8;
    external_ref_clock <= (cyc % 8) < 4;
    internal_ref_clock <= (cyc % 24) < 12;
    irq_q <= match_irq;
    if (match_irq && !irq_q) begin
      n_rise <= n_rise + 1;
      t_rise <= cyc;
    end
  end

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check(s_axi_rdata, exq.pop_front());
  end

  always @(posedge aclk) begin
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic aw_done = 0;
    logic w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awready && !aw_done) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1;
      end
      if (s_axi_wready && !w_done) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1;
      end
    end
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge aclk);
    exq.push_back({24'h0, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_rise(input int k);
    while (n_rise == k) @(posedge aclk);
  endtask

  initial begin
    void'($urandom(55));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_STATUS_CONTROL, 8'h00);
    rd(OFF_CURRENT_COUNT, 8'h00);
    rd(OFF_COMPARE_MOD, 8'h00);
    rd(4'hC, 8'h00);
    n = $urandom_range(255);
    wr(OFF_COMPARE_MOD, n[7:0]);
    rd(OFF_COMPARE_MOD, n[7:0]);
    wr(OFF_CURRENT_COUNT, 8'hFF);
    rd(OFF_CURRENT_COUNT, 8'h00);
    for (int i = 0; i < 10; i++) begin
      n = n_rise;
      wr(OFF_STATUS_CONTROL, cfg[i] | 8'h90);
      wr(OFF_COMPARE_MOD, md[i]);
      wait_rise(n);
      t0 = t_rise;
      n = n_rise;
      wr(OFF_STATUS_CONTROL, cfg[i] | 8'h90);
      wait_rise(n);
      check(32'(t_rise - t0), 32'(gap[i]));
      rd(OFF_CURRENT_COUNT, 8'h00);
      rd(OFF_STATUS_CONTROL, cfg[i] | 8'h90);
    end
    // Polling with the interrupt disabled, zero write keeps the flag
    wr(OFF_STATUS_CONTROL, 8'h88);
    repeat (40) @(posedge aclk);
    check({31'h0, match_irq}, 32'h0);
    wr(OFF_STATUS_CONTROL, 8'h08);
    rd(OFF_STATUS_CONTROL, 8'h88);
    wr(OFF_STATUS_CONTROL, 8'h90);
    repeat (64) @(posedge aclk);
    rd(OFF_STATUS_CONTROL, 8'h10);
    rd(OFF_CURRENT_COUNT, 8'h00);
    debug_halt <= 1'b1;
    // Let the halt pass its synchroniser before counting is enabled
    repeat (8) @(posedge aclk);
    wr(OFF_STATUS_CONTROL, 8'h98);
    repeat (64) @(posedge aclk);
    check({31'h0, match_irq}, 32'h0);
    n = n_rise;
    debug_halt <= 1'b0;
    wait_rise(n);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_STATUS_CONTROL, 8'h00);
    rd(OFF_COMPARE_MOD, 8'h00);
    complete_run();
  end
endmodule

// ==== rtl/pwc_pkg.sv ====
// Package for the periodic wakeup counter: offsets, fields, resets, types
package pwc_pkg;

  // Register byte offsets
  localparam logic [3:0] OFF_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFF_CURRENT_COUNT  = 4'h4;
  localparam logic [3:0] OFF_COMPARE_MOD    = 4'h8;

  // Status/control field positions
  localparam int FLAG_BIT     = 7;
  localparam int CLKSEL_LSB   = 5;
  localparam int IRQEN_BIT    = 4;
  localparam int PRESEL_LSB   = 0;

  // Reset values
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] MODULO_RESET  = 8'h00;
  localparam logic [1:0] CLKSEL_RESET  = 2'h0;
  localparam logic [3:0] PRESEL_RESET  = 4'h0;

  // Clock source codes
  localparam logic [1:0] SRC_LOW_POWER = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL  = 2'h1;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       match_flag;
    logic [1:0] clock_source_select;
    logic       match_irq_enable;
    logic [3:0] prescaler_select;
  } pwc_ctrl_t;

  // Divider ratio for prescaler code and clock-source low bit (0 = off)
  function automatic logic [17:0] pwc_divide(input logic sel0, input logic [3:0] code);
    logic [17:0] d;
    d = 18'h0;
    if (!sel0) begin
      unique case (code)
        4'h0: d = 18'h0;
        4'h1: d = 18'h8;
        4'h2: d = 18'h20;
        4'h3: d = 18'h40;
        4'h4: d = 18'h80;
        4'h5: d = 18'h100;
        4'h6: d = 18'h200;
        4'h7: d = 18'h400;
        4'h8: d = 18'h1;
        4'h9: d = 18'h2;
        4'hA: d = 18'h4;
        4'hB: d = 18'hA;
        4'hC: d = 18'h10;
        4'hD: d = 18'h64;
        4'hE: d = 18'h1F4;
        4'hF: d = 18'h3E8;
      endcase
    end else begin
      unique case (code)
        4'h0: d = 18'h0;
        4'h1: d = 18'h400;
        4'h2: d = 18'h800;
        4'h3: d = 18'h1000;
        4'h4: d = 18'h2000;
        4'h5: d = 18'h4000;
        4'h6: d = 18'h8000;
        4'h7: d = 18'h10000;
        4'h8: d = 18'h3E8;
        4'h9: d = 18'h7D0;
        4'hA: d = 18'h1388;
        4'hB: d = 18'h2710;
        4'hC: d = 18'h4E20;
        4'hD: d = 18'hC350;
        4'hE: d = 18'h186A0;
        4'hF: d = 18'h30D40;
      endcase
    end
    return d;
  endfunction

endpackage

// ==== rtl/pwc_top.sv ====
// Periodic wakeup counter with AXI4-Lite register slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module pwc_top
  import pwc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Counting clock sources, asynchronous to aclk
  input  wire logic        low_power_osc_clock,
  input  wire logic        external_ref_clock,
  input  wire logic        internal_ref_clock,
  // Debug halt
  input  wire logic        debug_halt,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt request
  output logic             match_irq
);

  pwc_ctrl_t   ctrl_r;
  logic [7:0]  modulo_r;
  logic [7:0]  count_r;
  logic [17:0] presc_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [3:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        w_strb0_r;
  logic        dbg_s1_r;
  logic        dbg_s2_r;
  logic        dbg_s3_r;
  logic        dbg_r;
  logic [2:0]  lpo_sync_r;
  logic [2:0]  ext_sync_r;
  logic [2:0]  int_sync_r;
  logic        src_lvl_r;

  // Synchronise every source; a rise of the selected source counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpo_sync_r <= 3'h0;
      ext_sync_r <= 3'h0;
      int_sync_r <= 3'h0;
      dbg_s1_r   <= 1'b0;
      dbg_s2_r   <= 1'b0;
      dbg_s3_r   <= 1'b0;
    end else begin
      lpo_sync_r <= {lpo_sync_r[1:0], low_power_osc_clock};
      ext_sync_r <= {ext_sync_r[1:0], external_ref_clock};
      int_sync_r <= {int_sync_r[1:0], internal_ref_clock};
      dbg_s1_r   <= debug_halt;
      dbg_s2_r   <= dbg_s1_r;
      dbg_s3_r   <= dbg_s2_r;
    end
  end

  // Source mux on settled stages
  wire [1:0] lpo_st = lpo_sync_r[2:1];
  wire [1:0] ext_st = ext_sync_r[2:1];
  wire [1:0] int_st = int_sync_r[2:1];
  wire [1:0] sel_st = (ctrl_r.clock_source_select == SRC_LOW_POWER) ? lpo_st :
                      (ctrl_r.clock_source_select == SRC_EXTERNAL)  ? ext_st :
                      int_st;
  wire       sel_agree = (sel_st[0] == sel_st[1]);
  wire       src_rise  = sel_agree && sel_st[1] && !src_lvl_r;
  wire       dbg_agree = (dbg_s2_r == dbg_s3_r);

  // Bus decode
  wire        wr_go      = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire        wr_sc      = wr_go && (aw_addr_r[3:2] == OFF_STATUS_CONTROL[3:2]) && w_strb0_r;
  wire        wr_cnt     = wr_go && (aw_addr_r[3:2] == OFF_CURRENT_COUNT[3:2]);
  wire        wr_mod     = wr_go && (aw_addr_r[3:2] == OFF_COMPARE_MOD[3:2]) && w_strb0_r;
  wire        wr_ok      = wr_sc || wr_cnt || wr_mod || (wr_go && !w_strb0_r &&
                           (aw_addr_r[3:2] != 2'h3));
  wire [7:0]  wbyte      = w_data_r[7:0];
  wire [1:0]  new_clksel = wbyte[CLKSEL_LSB +: 2];
  wire [3:0]  new_presel = wbyte[PRESEL_LSB +: 4];
  wire        cfg_change = wr_sc && ((new_clksel != ctrl_r.clock_source_select) ||
                           (new_presel != ctrl_r.prescaler_select));
  wire        restart    = wr_mod || cfg_change;

  // Counting
  wire [17:0] divide     = pwc_divide(ctrl_r.clock_source_select[0], ctrl_r.prescaler_select);
  wire        presc_on   = (ctrl_r.prescaler_select != PRESEL_RESET);
  wire        run        = presc_on && !dbg_r && src_rise;
  wire        presc_tick = run && (presc_r == divide - 18'h1);
  wire        wrap       = presc_tick && (count_r == modulo_r);
  wire        flag_clr   = wr_sc && wbyte[FLAG_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_lvl_r <= 1'b0;
      dbg_r     <= 1'b0;
    end else begin
      if (sel_agree) begin
        src_lvl_r <= sel_st[1];
      end
      if (dbg_agree) begin
        dbg_r <= dbg_s3_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 18'h0;
      count_r <= COUNT_RESET;
    end else if (restart || !presc_on) begin
      presc_r <= 18'h0;
      count_r <= COUNT_RESET;
    end else if (run) begin
      presc_r <= presc_tick ? 18'h0 : presc_r + 18'h1;
      if (presc_tick) begin
        count_r <= wrap ? COUNT_RESET : count_r + 8'h1;
      end
    end
  end

  // Control and modulo registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r.match_flag          <= 1'b0;
      ctrl_r.clock_source_select <= CLKSEL_RESET;
      ctrl_r.match_irq_enable    <= 1'b0;
      ctrl_r.prescaler_select    <= PRESEL_RESET;
      modulo_r                   <= MODULO_RESET;
    end else begin
      if (wrap) begin
        ctrl_r.match_flag <= 1'b1;
      end else if (flag_clr) begin
        ctrl_r.match_flag <= 1'b0;
      end
      if (wr_sc) begin
        ctrl_r.clock_source_select <= new_clksel;
        ctrl_r.match_irq_enable    <= wbyte[IRQEN_BIT];
        ctrl_r.prescaler_select    <= new_presel;
      end
      if (wr_mod) begin
        modulo_r <= wbyte;
      end
    end
  end

  assign match_irq = ctrl_r.match_flag && ctrl_r.match_irq_enable;

  // AXI4-Lite write path: address and data captured independently
  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready  = !w_hold_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 4'h0;
      w_data_r     <= 32'h0;
      w_strb0_r    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path: whole snapshot taken in one cycle, never torn
  wire [7:0] sc_read  = {ctrl_r.match_flag, ctrl_r.clock_source_select,
                         ctrl_r.match_irq_enable, ctrl_r.prescaler_select};
  wire       rd_map   = (s_axi_araddr[3:2] != 2'h3);
  wire [7:0] rd_byte  = (s_axi_araddr[3:2] == OFF_STATUS_CONTROL[3:2]) ? sc_read :
                        (s_axi_araddr[3:2] == OFF_CURRENT_COUNT[3:2])  ? count_r :
                        (s_axi_araddr[3:2] == OFF_COMPARE_MOD[3:2])    ? modulo_r :
                        8'h00;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rd_byte};
      s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
